// >>> hdl/ifr_consts.vh
`ifndef IFR_CONSTS_VH
`define IFR_CONSTS_VH
// register byte offsets
`define IFR_A_FILT 12'h000
`define IFR_A_UMODE 12'h040
`define IFR_A_CMD 12'h050
`define IFR_A_STAT 12'h054
`define IFR_A_SLOT 12'h400
`define IFR_SLOT_HI 3'h2
// slot sub-registers, word index inside a 16-byte slot
`define IFR_S_CTL 2'd0
`define IFR_S_SPN 2'd1
`define IFR_S_DLY 2'd2
`define IFR_S_STS 2'd3
// field positions
`define IFR_F_FCONST_LSB 8
`define IFR_F_FMI_LSB 8
`define IFR_F_MSG 1
`define IFR_F_EN 0
`define IFR_F_ACT 31
`define IFR_CMD_CLRPREV 0
`define IFR_CMD_CLRACT 1
// filter types
`define IFR_FT_NONE 2'd0
`define IFR_FT_MAVG 2'd1
`define IFR_FT_RAVG 2'd2
// universal input sensor codes
`define IFR_M_DIS 7'd0
`define IFR_M_V5 7'd12
`define IFR_M_I20 7'd20
`define IFR_M_I420 7'd21
`define IFR_M_F50 7'd40
`define IFR_M_F1K 7'd41
`define IFR_M_F10K 7'd42
`define IFR_M_PWML 7'd50
`define IFR_M_PWMH 7'd51
`define IFR_M_DIG 7'd61
`define IFR_M_THRM 7'd70
// reset values
`define IFR_UMODE_RST `IFR_M_V5
`define IFR_FCONST_RST 8'h0a
`define IFR_DLY_RST 16'h03e8
`define IFR_SPN_RST 19'h7f000
`define IFR_FMI_RST 5'h0c
// message kinds and broadcast address
`define IFR_K_ACTIVE 2'd1
`define IFR_K_PREV 2'd2
`define IFR_BCAST 8'hff
// timing
`define IFR_CLK_HZ 100000000
`define IFR_TICK_US 1000
// sized counts below are the figures above worked out at their widths
`define IFR_TICK_CYC 17'd100000
`define IFR_PERIOD_MS 1000
`define IFR_HOLD_S 5
`define IFR_PERIOD_TICKS 13'd1000
`define IFR_HOLD_TICKS 13'd5000
// timer prescale divisors, cycles per timer count
`define IFR_PRE_SLOW 14'd10000
`define IFR_PRE_MID 14'd1000
`define IFR_PRE_FAST 14'd100
`endif

// >>> hdl/ifr_top.v
`timescale 1ns/1ps
`include "ifr_consts.vh"

module ifr_top #(
  parameter [16:0] TICK_CYC = `IFR_TICK_CYC,
  parameter [12:0] PERIOD_TICKS = `IFR_PERIOD_TICKS,
  parameter [12:0] HOLD_TICKS = `IFR_HOLD_TICKS,
  parameter [13:0] PRE_SLOW = `IFR_PRE_SLOW
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire [11:0] paddr_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire smp_valid_i,
  input wire [3:0] smp_chan_i,
  input wire [15:0] smp_data_i,
  input wire [2:0] uin_pin_i,
  input wire [21:0] fault_i,
  input wire req_active_i,
  input wire req_prev_i,
  input wire [7:0] req_addr_i,
  input wire clr_prev_i,
  input wire clr_active_i,
  input wire [4:0] dtc_sel_i,
  output reg filt_valid_o,
  output reg [3:0] filt_chan_o,
  output reg [15:0] filt_data_o,
  output reg msg_send_o,
  output reg [1:0] msg_kind_o,
  output reg msg_multi_o,
  output reg [7:0] msg_dest_o,
  output reg [4:0] msg_count_o,
  output reg [31:0] dtc_o,
  output reg dtc_active_o,
  output reg dtc_prev_o
);

  // configuration and state arrays
  reg [1:0] ftype [0:10];
  reg [7:0] fconst [0:10];
  reg [6:0] umode [0:2];
  reg [15:0] fval [0:13];
  reg [23:0] acc [0:13];
  reg [7:0] rcnt [0:13];
  reg [21:0] s_en;
  reg [21:0] s_msg;
  reg [21:0] s_act;
  reg [4:0] s_fmi [0:21];
  reg [18:0] s_spn [0:21];
  reg [15:0] s_dly [0:21];
  reg [15:0] s_tmr [0:21];
  reg [6:0] s_oc [0:21];

  // apb decode; one wait state since pready comes from a flop
  wire acc_ph = psel_i & penable_i;
  wire wr = ce_i & acc_ph & pready_o & pwrite_i;
  wire [3:0] fidx = paddr_i[5:2];
  wire [1:0] uidx = paddr_i[3:2];
  wire [4:0] sidx = paddr_i[8:4];
  wire [1:0] ssub = paddr_i[3:2];
  wire hit_f = (paddr_i[11:6] == `IFR_A_FILT >> 6) && (fidx < 4'd11);
  wire hit_u = (paddr_i[11:4] == `IFR_A_UMODE >> 4) && (uidx != 2'd3);
  wire hit_c = (paddr_i == `IFR_A_CMD);
  wire hit_st = (paddr_i == `IFR_A_STAT);
  wire hit_s = (paddr_i[11:9] == `IFR_SLOT_HI) && (sidx < 5'd22);
  wire hit = hit_f | hit_u | hit_c | hit_st | hit_s;
  wire cmd_wr = wr & hit_c;
  wire clr_prev = clr_prev_i | (cmd_wr & pwdata_i[`IFR_CMD_CLRPREV]);
  wire clr_act = clr_active_i | (cmd_wr & pwdata_i[`IFR_CMD_CLRACT]);

  // millisecond tick drives all delay and broadcast timing
  reg [16:0] tcnt;
  reg tick;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tcnt <= 17'h0;
      tick <= 1'b0;
    end else if (ce_i) begin
      tick <= (tcnt == TICK_CYC - 17'h1);
      tcnt <= (tcnt == TICK_CYC - 17'h1) ? 17'h0 : tcnt + 17'h1;
    end
  end

  // universal pins cross in through two flops
  reg [2:0] upin_a;
  reg [2:0] upin;
  reg [2:0] upin_d;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      upin_a <= 3'h0;
      upin <= 3'h0;
      upin_d <= 3'h0;
    end else if (ce_i) begin
      upin_a <= uin_pin_i;
      upin <= upin_a;
      upin_d <= upin;
    end
  end

  // timer count rate follows the range of the group's lead input
  function [13:0] ifr_pre;
    input [6:0] m;
    begin
      case (m)
        `IFR_M_F50: ifr_pre = PRE_SLOW;
        `IFR_M_F10K, `IFR_M_PWMH: ifr_pre = `IFR_PRE_FAST;
        default: ifr_pre = `IFR_PRE_MID;
      endcase
    end
  endfunction

  // 15-bit timers; group 1 is shared by inputs two and three, so
  // input three inherits input two's range
  reg [14:0] gt [0:1];
  reg [13:0] pc [0:1];
  reg [14:0] rise_t [0:2];
  reg [14:0] uper [0:2];
  reg [14:0] uhigh [0:2];
  always @(posedge clk_i or negedge reset_n_i) begin : ifr_tmr_p
    integer i;
    if (!reset_n_i) begin
      for (i = 0; i < 2; i = i + 1) begin
        gt[i] <= 15'h0;
        pc[i] <= 14'h0;
      end
      for (i = 0; i < 3; i = i + 1) begin
        rise_t[i] <= 15'h0;
        uper[i] <= 15'h0;
        uhigh[i] <= 15'h0;
      end
    end else if (ce_i) begin
      for (i = 0; i < 2; i = i + 1) begin
        if (pc[i] >= ifr_pre(umode[i]) - 14'h1) begin
          pc[i] <= 14'h0;
          gt[i] <= gt[i] + 15'h1;
        end else begin
          pc[i] <= pc[i] + 14'h1;
        end
      end
      for (i = 0; i < 3; i = i + 1) begin
        // period between rising edges, high time up to falling edge
        if (upin[i] & ~upin_d[i]) begin
          uper[i] <= gt[(i == 0) ? 0 : 1] - rise_t[i];
          rise_t[i] <= gt[(i == 0) ? 0 : 1];
        end
        if (~upin[i] & upin_d[i])
          uhigh[i] <= gt[(i == 0) ? 0 : 1] - rise_t[i];
      end
    end
  end

  // sample path: mode decode and filter arithmetic
  reg [3:0] fs;
  reg [7:0] fk;
  reg [15:0] v;
  reg drop;
  reg [3:0] c7;
  reg [17:0] dif;
  reg [17:0] q;
  reg [23:0] sum;
  reg [23:0] rdiv;
  reg rdone;
  always @* begin
    fs = (smp_chan_i < 4'd10) ? smp_chan_i : 4'd10;
    fk = (fconst[fs] == 8'h0) ? 8'h1 : fconst[fs];
    v = smp_data_i;
    drop = (smp_chan_i > 4'd13);
    c7 = smp_chan_i - 4'd7;
    if (smp_chan_i >= 4'd7 && smp_chan_i <= 4'd9) begin
      case (umode[c7[1:0]])
        `IFR_M_DIS: drop = 1'b1;
        `IFR_M_DIG: v = {15'h0, upin[c7[1:0]]};
        `IFR_M_F50, `IFR_M_F1K, `IFR_M_F10K: v = {1'b0, uper[c7[1:0]]};
        `IFR_M_PWML, `IFR_M_PWMH: v = {1'b0, uhigh[c7[1:0]]};
        default: v = smp_data_i;
      endcase
    end
    dif = {2'b00, v} - {2'b00, fval[smp_chan_i]};
    q = $signed(dif) / $signed({10'h0, fk});
    sum = acc[smp_chan_i] + {8'h0, v};
    rdiv = sum / {16'h0, fk};
    rdone = ({1'b0, rcnt[smp_chan_i]} + 9'h1) >= {1'b0, fk};
  end

  // filter state; repeating average only emits on the nth reading
  always @(posedge clk_i or negedge reset_n_i) begin : ifr_filt_p
    integer i;
    if (!reset_n_i) begin
      for (i = 0; i < 14; i = i + 1) begin
        fval[i] <= 16'h0;
        acc[i] <= 24'h0;
        rcnt[i] <= 8'h0;
      end
      filt_valid_o <= 1'b0;
      filt_chan_o <= 4'h0;
      filt_data_o <= 16'h0;
    end else if (ce_i) begin
      filt_valid_o <= 1'b0;
      if (smp_valid_i && !drop) begin
        filt_chan_o <= smp_chan_i;
        case (ftype[fs])
          `IFR_FT_MAVG: begin
            fval[smp_chan_i] <= fval[smp_chan_i] + q[15:0];
            filt_data_o <= fval[smp_chan_i] + q[15:0];
            filt_valid_o <= 1'b1;
          end
          `IFR_FT_RAVG: begin
            if (rdone) begin
              acc[smp_chan_i] <= 24'h0;
              rcnt[smp_chan_i] <= 8'h0;
              fval[smp_chan_i] <= rdiv[15:0];
              filt_data_o <= rdiv[15:0];
              filt_valid_o <= 1'b1;
            end else begin
              acc[smp_chan_i] <= sum;
              rcnt[smp_chan_i] <= rcnt[smp_chan_i] + 8'h1;
            end
          end
          default: begin
            fval[smp_chan_i] <= v;
            filt_data_o <= v;
            filt_valid_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // filter and universal mode registers, software only
  always @(posedge clk_i or negedge reset_n_i) begin : ifr_cfg_p
    integer i;
    if (!reset_n_i) begin
      for (i = 0; i < 11; i = i + 1) begin
        ftype[i] <= `IFR_FT_NONE;
        fconst[i] <= `IFR_FCONST_RST;
      end
      for (i = 0; i < 3; i = i + 1)
        umode[i] <= `IFR_UMODE_RST;
    end else if (wr) begin
      if (hit_f) begin
        ftype[fidx] <= pwdata_i[1:0];
        fconst[fidx] <= pwdata_i[`IFR_F_FCONST_LSB +: 8];
      end
      if (hit_u)
        umode[uidx] <= pwdata_i[6:0];
    end
  end

  // a slot activates once its fault has outlasted the delay
  wire [21:0] rise;
  genvar g;
  generate
    for (g = 0; g < 22; g = g + 1) begin : g_rise
      assign rise[g] = s_en[g] & fault_i[g] & ~s_act[g]
        & (s_tmr[g] == 16'h0);
    end
  endgenerate

  // diagnostic slots: 0-9 one per analog/universal input,
  // 10-21 three per thermocouple (shutdown, warning, open)
  always @(posedge clk_i or negedge reset_n_i) begin : ifr_slot_p
    integer i;
    if (!reset_n_i) begin
      s_en <= 22'h0;
      s_msg <= 22'h0;
      s_act <= 22'h0;
      for (i = 0; i < 22; i = i + 1) begin
        s_fmi[i] <= `IFR_FMI_RST;
        s_spn[i] <= `IFR_SPN_RST;
        s_dly[i] <= `IFR_DLY_RST;
        s_tmr[i] <= `IFR_DLY_RST;
        s_oc[i] <= 7'h0;
      end
    end else if (ce_i) begin
      for (i = 0; i < 22; i = i + 1) begin
        // clears first so that a same-cycle activation wins
        if (clr_prev && !s_act[i])
          s_oc[i] <= 7'h0;
        if (clr_act)
          s_act[i] <= 1'b0;
        if (wr && hit_s && sidx == i) begin
          case (ssub)
            `IFR_S_CTL: begin
              s_en[i] <= pwdata_i[`IFR_F_EN];
              s_msg[i] <= pwdata_i[`IFR_F_MSG];
              s_fmi[i] <= pwdata_i[`IFR_F_FMI_LSB +: 5];
            end
            `IFR_S_SPN: begin
              s_spn[i] <= pwdata_i[18:0];
              s_oc[i] <= 7'h0;
            end
            `IFR_S_DLY: s_dly[i] <= pwdata_i[15:0];
            default: ; // status is read-only, a clear must not be undone
          endcase
        end
        if (!s_en[i]) begin
          s_act[i] <= 1'b0;
          s_tmr[i] <= s_dly[i];
        end else if (!fault_i[i] || s_act[i]) begin
          s_tmr[i] <= s_dly[i];
        end else if (rise[i]) begin
          s_act[i] <= 1'b1;
          if (s_oc[i] != 7'h7f)
            s_oc[i] <= s_oc[i] + 7'h1;
        end else if (tick) begin
          s_tmr[i] <= s_tmr[i] - 16'h1;
        end
      end
    end
  end

  function [4:0] ifr_pop;
    input [21:0] b;
    integer j;
    begin
      ifr_pop = 5'h0;
      for (j = 0; j < 22; j = j + 1)
        ifr_pop = ifr_pop + {4'h0, b[j]};
    end
  endfunction

  // codes counted for the active and the previously active lists
  wire [21:0] prev_map;
  generate
    for (g = 0; g < 22; g = g + 1) begin : g_prev
      assign prev_map[g] = s_en[g] & (s_oc[g] != 7'h0);
    end
  endgenerate
  wire [21:0] act_map = s_act & s_msg & s_en;
  wire [4:0] act_cnt = ifr_pop(act_map);
  wire [4:0] prev_cnt = ifr_pop(prev_map);

  // broadcast scheduling; requests wait in pending flags so a
  // collision with a broadcast never loses one
  reg [12:0] hcnt;
  reg hold_done;
  reg [12:0] pcnt;
  reg act_any_d;
  reg pend_b;
  reg pend_a;
  reg pend_p;
  reg [7:0] addr_a;
  reg [7:0] addr_p;
  wire brd_evt = (tick && pcnt == PERIOD_TICKS - 13'h1)
    || (|(rise & s_msg))
    || (act_any_d && act_map == 22'h0);
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hcnt <= 13'h0;
      hold_done <= 1'b0;
      pcnt <= 13'h0;
      act_any_d <= 1'b0;
      pend_b <= 1'b0;
      pend_a <= 1'b0;
      pend_p <= 1'b0;
      addr_a <= 8'h0;
      addr_p <= 8'h0;
      msg_send_o <= 1'b0;
      msg_kind_o <= 2'h0;
      msg_multi_o <= 1'b0;
      msg_dest_o <= 8'h0;
      msg_count_o <= 5'h0;
    end else if (ce_i) begin
      act_any_d <= |act_map;
      if (tick && !hold_done) begin
        hcnt <= hcnt + 13'h1;
        hold_done <= (hcnt == HOLD_TICKS - 13'h1);
      end
      if (tick)
        pcnt <= (pcnt == PERIOD_TICKS - 13'h1) ? 13'h0 : pcnt + 13'h1;
      msg_send_o <= 1'b0;
      if (req_active_i) begin
        pend_a <= 1'b1;
        addr_a <= req_addr_i;
      end
      if (req_prev_i) begin
        pend_p <= 1'b1;
        addr_p <= req_addr_i;
      end
      if (pend_b) begin
        pend_b <= 1'b0;
        msg_send_o <= 1'b1;
        msg_kind_o <= `IFR_K_ACTIVE;
        msg_dest_o <= `IFR_BCAST;
        msg_count_o <= act_cnt;
        msg_multi_o <= (act_cnt > 5'h1);
      end else if (pend_a && !req_active_i) begin
        pend_a <= 1'b0;
        msg_send_o <= 1'b1;
        msg_kind_o <= `IFR_K_ACTIVE;
        msg_dest_o <= addr_a;
        msg_count_o <= act_cnt;
        msg_multi_o <= (act_cnt > 5'h1);
      end else if (pend_p && !req_prev_i) begin
        pend_p <= 1'b0;
        msg_send_o <= 1'b1;
        msg_kind_o <= `IFR_K_PREV;
        msg_dest_o <= addr_p;
        msg_count_o <= prev_cnt;
        msg_multi_o <= (prev_cnt > 5'h1);
      end
      // set after the service so an event in the serving cycle is kept
      if (hold_done && (|(s_msg & s_en)) && brd_evt)
        pend_b <= 1'b1;
    end
  end

  // trouble code read port: spn low 16, spn top 3 with fmi, cm and oc
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dtc_o <= 32'h0;
      dtc_active_o <= 1'b0;
      dtc_prev_o <= 1'b0;
    end else if (ce_i) begin
      if (dtc_sel_i < 5'd22) begin
        dtc_o <= {1'b0, s_oc[dtc_sel_i], s_spn[dtc_sel_i][18:16],
          s_fmi[dtc_sel_i], s_spn[dtc_sel_i][15:0]};
        dtc_active_o <= act_map[dtc_sel_i];
        dtc_prev_o <= prev_map[dtc_sel_i];
      end else begin
        dtc_o <= 32'h0;
        dtc_active_o <= 1'b0;
        dtc_prev_o <= 1'b0;
      end
    end
  end

  // apb read mux
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0;
    if (hit_f)
      next_rdata = {16'h0, fconst[fidx], 6'h0, ftype[fidx]};
    else if (hit_u)
      next_rdata = {25'h0, umode[uidx]};
    else if (hit_st)
      next_rdata = {hold_done, 18'h0, act_cnt, 3'h0, prev_cnt};
    else if (hit_s) begin
      case (ssub)
        `IFR_S_CTL: next_rdata = {19'h0, s_fmi[sidx], 6'h0,
          s_msg[sidx], s_en[sidx]};
        `IFR_S_SPN: next_rdata = {13'h0, s_spn[sidx]};
        `IFR_S_DLY: next_rdata = {16'h0, s_dly[sidx]};
        default: next_rdata = {s_act[sidx], 24'h0, s_oc[sidx]};
      endcase
    end
  end

  // apb answer: pready rises one cycle into the access phase
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= acc_ph & ~pready_o;
      pslverr_o <= acc_ph & ~pready_o & ~hit;
      prdata_o <= (acc_ph & ~pready_o & ~pwrite_i) ? next_rdata : 32'h0;
    end
  end

endmodule

// >>> tb/ifr_top_sva.sv
`timescale 1ns/1ps
module ifr_chk #(
  parameter [16:0] TICK_CYC = 17'd10,
  parameter [12:0] HOLD_TICKS = 13'd30
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  input wire smp_valid_i,
  input wire [3:0] smp_chan_i,
  input wire req_active_i,
  input wire filt_valid_o,
  input wire [3:0] filt_chan_o,
  input wire msg_send_o,
  input wire msg_multi_o,
  input wire [7:0] msg_dest_o,
  input wire [4:0] msg_count_o,
  input wire [31:0] dtc_o,
  input wire dtc_prev_o
);
  reg [31:0] cyc;
  wire [31:0] lim;
  // cycles since reset, saturating so a long run cannot wrap into hold-off
  assign lim = HOLD_TICKS * TICK_CYC;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cyc <= 32'h0;
    else if (ce_i && cyc != 32'hffffffff) cyc <= cyc + 32'h1;
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_wait;
    psel_i && penable_i && !pready_o && ce_i |=> pready_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_rdy;
    pready_o |=> !pready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready held too long");
  property p_drop;
    (!smp_valid_i || smp_chan_i > 4'hd) && ce_i |=> !filt_valid_o;
  endproperty
  a_drop: assert property (p_drop) else $error("sample not dropped");
  property p_chan;
    filt_valid_o |-> filt_chan_o == $past(smp_chan_i);
  endproperty
  a_chan: assert property (p_chan) else $error("channel mixed up");
  property p_cm;
    dtc_o[31] == 1'b0;
  endproperty
  a_cm: assert property (p_cm) else $error("conversion bit set");
  property p_req;
    req_active_i && ce_i |-> ##[2:6] msg_send_o;
  endproperty
  a_req: assert property (p_req) else $error("request unanswered");
  property p_multi;
    msg_send_o |-> msg_multi_o == (msg_count_o > 5'h1);
  endproperty
  a_multi: assert property (p_multi) else $error("bad multi flag");
  property p_hold;
    msg_send_o && msg_dest_o == 8'hff |-> cyc + 32'h4 >= lim;
  endproperty
  a_hold: assert property (p_hold) else $error("early broadcast");
  property p_prev;
    dtc_prev_o |-> dtc_o[30:24] != 7'h0;
  endproperty
  a_prev: assert property (p_prev) else $error("previous with no count");
  c_filt: cover property (filt_valid_o);
  c_multi: cover property (msg_send_o && msg_multi_o);
  c_prev: cover property (dtc_prev_o);
endmodule

bind ifr_top ifr_chk #(.TICK_CYC(TICK_CYC), .HOLD_TICKS(HOLD_TICKS)) i_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .smp_valid_i(smp_valid_i),
  .smp_chan_i(smp_chan_i), .req_active_i(req_active_i),
  .filt_valid_o(filt_valid_o), .filt_chan_o(filt_chan_o),
  .msg_send_o(msg_send_o), .msg_multi_o(msg_multi_o),
  .msg_dest_o(msg_dest_o), .msg_count_o(msg_count_o), .dtc_o(dtc_o),
  .dtc_prev_o(dtc_prev_o));

// >>> tb/ifr_net_model.sv
`timescale 1ns/1ps
module ifr_net_model (
  input wire clk_i,
  output reg req_active_o,
  output reg req_prev_o,
  output reg clr_prev_o,
  output reg clr_active_o,
  output reg [7:0] req_addr_o
);
  // network idle at power-up
  initial begin
    {req_active_o, req_prev_o, clr_prev_o, clr_active_o} = 4'h0;
    req_addr_o = 8'h00;
  end
  // one-cycle request: 0 active list, 1 previous, 2 clear prev, 3 clear
  // idle address is scrambled so a stale requester cannot pass for a match
  task send(input [1:0] k, input [7:0] a);
    begin
      @(posedge clk_i);
      req_addr_o <= a;
      req_active_o <= (k == 2'd0);
      req_prev_o <= (k == 2'd1);
      clr_prev_o <= (k == 2'd2);
      clr_active_o <= (k == 2'd3);
      @(posedge clk_i);
      {req_active_o, req_prev_o, clr_prev_o, clr_active_o} <= 4'h0;
      req_addr_o <= ~a;
    end
  endtask
endmodule

// >>> tb/tb_input_filter_fault_reporter.sv
`timescale 1ns/1ps
`include "ifr_consts.vh"
module tb_input_filter_fault_reporter;
  localparam [87:0] CODES = {8'd70, 8'd61, 8'd51, 8'd50, 8'd42, 8'd41,
    8'd40, 8'd21, 8'd20, 8'd12, 8'd0};
  reg clk_i = 1'b0;
  reg ce = 1'b1;
  reg reset_n_i = 1'b0;
  reg psel = 1'b0, pen = 1'b0, pwr = 1'b0, sv = 1'b0;
  reg [11:0] pa = 12'h0;
  reg [31:0] pwd = 32'h0, r;
  reg [3:0] sc = 4'h0;
  reg [15:0] sd = 16'h0;
  reg [2:0] pin = 3'h1;
  reg [21:0] fault = 22'h0;
  reg [4:0] sel = 5'h0;
  reg [7:0] code;
  reg e;
  wire [31:0] prd, dtc;
  wire rdy, err, fv, ms, mm, dact, dprev, ra, rp, cp, ca;
  wire [3:0] fch;
  wire [15:0] fd;
  wire [1:0] mk;
  wire [7:0] md, rad;
  wire [4:0] mc;
  integer bad_count = 0, checked = 0, i, n;
  always #5 clk_i = ~clk_i;
  // short tick, period and hold-off keep the run brief
  ifr_top #(.TICK_CYC(17'd10), .PERIOD_TICKS(13'd20), .HOLD_TICKS(13'd30),
    .PRE_SLOW(14'd4)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .ce_i(ce), .paddr_i(pa), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .smp_valid_i(sv), .smp_chan_i(sc), .smp_data_i(sd),
    .uin_pin_i(pin), .fault_i(fault), .req_active_i(ra), .req_prev_i(rp),
    .req_addr_i(rad), .clr_prev_i(cp), .clr_active_i(ca), .dtc_sel_i(sel),
    .filt_valid_o(fv), .filt_chan_o(fch), .filt_data_o(fd),
    .msg_send_o(ms), .msg_kind_o(mk), .msg_multi_o(mm), .msg_dest_o(md),
    .msg_count_o(mc), .dtc_o(dtc), .dtc_active_o(dact),
    .dtc_prev_o(dprev));
  ifr_net_model i_net (.clk_i(clk_i), .req_active_o(ra), .req_prev_o(rp),
    .clr_prev_o(cp), .clr_active_o(ca), .req_addr_o(rad));
  task close_out;
    begin
      $display("checks %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      checked = checked + 1;
      if (g !== x) begin
        bad_count = bad_count + 1;
        $display("Error at %0t seen %h expected %h", $time, g, x);
      end
    end
  endtask
  // one bus transfer; the first edge keeps back-to-back calls apart
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk_i);
      pen <= 1'b1;
      @(posedge clk_i);
      while (rdy !== 1'b1) @(posedge clk_i);
      r = prd;
      e = err;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  // one sample, returns in the cycle the filtered result stands
  task smp(input [3:0] c, input [15:0] d);
    begin
      @(posedge clk_i);
      sv <= 1'b1;
      sc <= c;
      sd <= d;
      @(posedge clk_i);
      sv <= 1'b0;
      sd <= ~d;
      @(posedge clk_i);
    end
  endtask
  task dsel(input [4:0] s);
    begin
      @(posedge clk_i);
      sel <= s;
      repeat (2) @(posedge clk_i);
    end
  endtask
  // next message to dest d carrying c codes, bounded wait
  task waitm(input [7:0] d, input [4:0] c);
    begin
      n = 0;
      while (!(ms === 1'b1 && md === d && mc === c) && n < 3000) begin
        @(posedge clk_i);
        n = n + 1;
      end
      chk(n < 3000, 1);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    bus(0, `IFR_A_UMODE, 0);
    chk(r, 32'h0c);
    bus(0, `IFR_A_FILT, 0);
    chk(r, 32'h0a00);
    bus(0, 12'h404, 0);
    chk(r, 32'h7f000);
    bus(0, 12'h408, 0);
    chk(r, 32'h3e8);
    bus(0, 12'h300, 0);
    chk({31'h0, e}, 1);
    chk(r, 0);
    // filter kinds, thermocouples on their shared setting
    smp(0, 16'd100);
    chk({fv, fch, fd}, {1'b1, 4'h0, 16'd100});
    // clock enable low: the sample is ignored and the output holds
    ce <= 1'b0;
    smp(0, 16'd77);
    chk({fv, fd}, {1'b0, 16'd100});
    ce <= 1'b1;
    bus(1, 12'h004, 32'h0401);
    smp(1, 16'd100);
    chk(fd, 25);
    smp(1, 16'd100);
    chk(fd, 43);
    bus(1, 12'h008, 32'h0302);
    smp(2, 16'd3);
    chk(fv, 0);
    smp(2, 16'd6);
    chk(fv, 0);
    smp(2, 16'd9);
    chk({fv, fd}, {1'b1, 16'd6});
    bus(1, 12'h028, 32'h0201);
    smp(10, 16'd100);
    chk(fd, 50);
    smp(13, 16'd100);
    chk({fch, fd}, {4'hd, 16'd50});
    smp(14, 16'd5);
    chk(fv, 0);
    // digital mode follows the synchronised pin
    bus(1, `IFR_A_UMODE, 61);
    for (i = 0; i < 2; i++) begin
      pin[0] <= i[0];
      repeat (4) @(posedge clk_i);
      smp(7, 16'hffff);
      chk(fd, i);
    end
    // every sensor code; inputs two and three always share a range
    for (i = 0; i < 11; i++) begin
      code = CODES[i*8 +: 8];
      bus(1, 12'h044, code);
      bus(1, 12'h048, code);
      smp(9, 16'h1234);
      chk(fv, code != 0);
      if (code == 12 || code == 20 || code == 21 || code == 70)
        chk(fd, 16'h1234);
      else if (code == 61) chk(fd, 0);
      else chk(fd[15], 0);
    end
    // slot 0 and 2 watched, slot 1 has detection off
    bus(1, 12'h400, 32'h0c03);
    bus(1, 12'h408, 3);
    bus(1, 12'h410, 32'h0c02);
    bus(1, 12'h418, 3);
    bus(1, 12'h420, 32'h0c03);
    bus(1, 12'h428, 3);
    r = 0;
    n = 0;
    while (!r[31] && n < 200) begin
      bus(0, `IFR_A_STAT, 0);
      n = n + 1;
    end
    chk(r[31], 1);
    // a glitch shorter than the delay must not activate
    fault <= 22'h3;
    repeat (10) @(posedge clk_i);
    fault <= 22'h2;
    dsel(0);
    chk(dact, 0);
    fault <= 22'h3;
    waitm(8'hff, 1);
    chk(mk, 1);
    dsel(0);
    chk(dact, 1);
    chk(dtc, 32'h01ecf000);
    dsel(1);
    chk({dact, dtc[30:24]}, 0);
    bus(0, 12'h40c, 0);
    chk(r, 32'h80000001);
    @(posedge clk_i);
    waitm(8'hff, 1);
    @(posedge clk_i);
    waitm(8'hff, 1);
    chk(n + 1, 200);
    i_net.send(0, 8'h21);
    waitm(8'h21, 1);
    chk({mk, mm}, {2'd1, 1'b0});
    fault <= 22'h7;
    waitm(8'hff, 2);
    i_net.send(0, 8'h33);
    waitm(8'h33, 2);
    chk({mk, mm}, {2'd1, 1'b1});
    // causes gone, codes stay until the network clears them
    fault <= 22'h2;
    repeat (100) @(posedge clk_i);
    dsel(2);
    chk(dact, 1);
    i_net.send(3, 8'h00);
    waitm(8'hff, 0);
    dsel(0);
    chk({dact, dprev, dtc[30:24]}, {2'b01, 7'd1});
    i_net.send(1, 8'h44);
    waitm(8'h44, 2);
    chk({mk, mm}, {2'd2, 1'b1});
    // repeated activations of slot 2 must not wrap its count
    fault <= 22'h6;
    for (i = 0; i < 130; i++) begin
      i_net.send(3, 8'h00);
      repeat (60) @(posedge clk_i);
    end
    dsel(2);
    chk(dtc[30:24], 7'h7f);
    fault <= 22'h2;
    i_net.send(3, 8'h00);
    fault <= 22'h3;
    repeat (60) @(posedge clk_i);
    i_net.send(2, 8'h00);
    dsel(2);
    chk(dtc[30:24], 0);
    dsel(0);
    chk({dact, dtc[30:24]}, {1'b1, 7'd2});
    bus(1, 12'h404, 32'h123);
    dsel(0);
    chk(dtc, 32'h000c0123);
    close_out;
  end
  // watchdog well beyond the expected nine thousand cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count = bad_count + 1;
    close_out;
  end
endmodule
